// ---- hw/frr_pkg.sv ----
package frr_pkg;
  // Bus
  localparam int AW = 5;
  localparam logic [AW-1:0] OFS_CTRL = 5'h00;
  localparam logic [AW-1:0] OFS_RST_SRC = 5'h04;
  localparam logic [AW-1:0] OFS_PRST_SRC = 5'h08;
  localparam logic [AW-1:0] OFS_LATCH = 5'h0C;
  localparam logic [AW-1:0] OFS_STATUS = 5'h10;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 5'h18;
  // Control fields
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_EXPERT = 1;
  localparam int CTRL_EXTFIT = 2;
  localparam int CTRL_IOPROF = 3;
  localparam int CTRL_RESTART = 4;
  localparam int CTRL_FRT_LO = 5;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  // Source selector: [4:0] input index or [3:0] command bit, [6:5] kind
  localparam int SRC_W = 7;
  localparam int IDX_W = 5;
  localparam logic [1:0] KIND_INPUT = 2'h0;
  localparam logic [1:0] KIND_BASE = 2'h1;
  localparam logic [1:0] KIND_SERIAL = 2'h2;
  localparam logic [1:0] KIND_FIELDBUS = 2'h3;
  localparam logic [SRC_W-1:0] RST_SRC_RESET = 7'h02;
  localparam logic [IDX_W-1:0] PRST_SRC_RESET = 5'h00;
  localparam logic [IDX_W-1:0] LOC_FIRST = 5'h01;
  localparam logic [IDX_W-1:0] LOC_LAST = 5'h06;
  localparam logic [IDX_W-1:0] EXT_FIRST = 5'h0B;
  localparam logic [IDX_W-1:0] EXT_LAST = 5'h10;
  localparam int NIN = 6;
  // Status and interrupt bits
  localparam int ST_LOCKED = 0;
  localparam int ST_AUTO = 1;
  localparam int ST_ABORTED = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_BUSY = 4;
  localparam int IRQ_W = 4;
  localparam int IRQ_MANUAL = 0;
  localparam int IRQ_RESTART = 1;
  localparam int IRQ_AUTO_OK = 2;
  localparam int IRQ_ABORT = 3;
  // Timing in seconds
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_S = 1;
  localparam int SEC_W = 16;
  localparam logic [SEC_W-1:0] WAIT1_S = 16'h0001;
  localparam logic [SEC_W-1:0] WAIT2_S = 16'h0005;
  localparam logic [SEC_W-1:0] WAIT3_S = 16'h000A;
  localparam logic [SEC_W-1:0] WAIT4_S = 16'h003C;
  localparam logic [SEC_W-1:0] FRT_5M_S = 16'h012C;
  localparam logic [SEC_W-1:0] FRT_10M_S = 16'h0258;
  localparam logic [SEC_W-1:0] FRT_30M_S = 16'h0708;
  localparam logic [SEC_W-1:0] FRT_1H_S = 16'h0E10;
  localparam logic [SEC_W-1:0] FRT_2H_S = 16'h1C20;
  localparam logic [SEC_W-1:0] FRT_3H_S = 16'h2A30;
  localparam logic [2:0] FRT_UNLIMITED = 3'h6;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_AR_WAIT, SEQ_ABORT, SEQ_RS_INIT
  } frr_seq_e;
endpackage

// ---- hw/frr_sync.sv ----
`timescale 1ns/10ps
module frr_sync #(
  parameter int W = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and synchronised levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign q = s2_reg;
  assign rise = s2_reg & ~s3_reg;
endmodule

// ---- hw/frr_ctrl.sv ----
`timescale 1ns/10ps
// Operation
// - Reset request clears latched errors only where the cause has gone.
// - Only errors in the clearable set are cleared by a reset request.
// - Keypad stop/reset key acts as an additional reset request.
// - Reset source: none, local inputs 1-6, extension 11-16; default local input 2.
// - Reset source may be a bit of base, serial or fieldbus command word.
// - Product restart does a fault reset, then the full power-up initialisation.
// - Restart command and its source work only at expert access level.
// - Restart command returns to no when initialisation completes.
// - Product restart is accepted only while locked in error.
// - Restart source: none by default, local 1-6, extension 11-16 if fitted.
// - Auto reset retries by itself and leaves fault when the cause disappears.
// - Fault output stays inactive while automatic attempts run.
// - Failed automatic attempts leave fault state with fault output active.
// - Attempt waits grow: 1 s, 5 s, 10 s, then 1 min each.
// - Beyond the maximum restart time, attempts abort and stay locked.
module frr_ctrl
  import frr_pkg::*;
#(
  parameter int NERR = 8,
  parameter logic [NERR-1:0] CLEARABLE = 8'h0F,
  parameter int TICK_CYCLES = CLK_HZ * TICK_S,
  parameter int INIT_CYCLES = 16,
  parameter logic [frr_pkg::SRC_W-1:0] RST_SRC_DEFAULT = frr_pkg::RST_SRC_RESET
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [frr_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Reset sources
  input wire logic [frr_pkg::NIN-1:0] local_input,
  input wire logic [frr_pkg::NIN-1:0] extension_input,
  input wire logic keypad_stop_key,
  input wire logic [15:0] base_cmd_word,
  input wire logic [15:0] serial_cmd_word,
  input wire logic [15:0] fieldbus_cmd_word,
  // Error causes
  input wire logic [NERR-1:0] err_cause,
  // Outputs
  output logic fault_state_out,
  output logic reinit_busy,
  output logic irq
);
  import frr_pkg::*;

  function automatic logic pick_input(input logic [IDX_W-1:0] idx,
      input logic [NIN-1:0] loc, input logic [NIN-1:0] ext, input logic fitted);
    logic r;
    r = 1'b0;
    if (idx >= LOC_FIRST && idx <= LOC_LAST) begin
      r = loc[3'(idx - LOC_FIRST)];
    end else if (idx >= EXT_FIRST && idx <= EXT_LAST && fitted) begin
      r = ext[3'(idx - EXT_FIRST)];
    end
    return r;
  endfunction

  function automatic logic [SEC_W-1:0] wait_s(input logic [1:0] att);
    case (att)
      2'h0: wait_s = WAIT1_S;
      2'h1: wait_s = WAIT2_S;
      2'h2: wait_s = WAIT3_S;
      default: wait_s = WAIT4_S;
    endcase
  endfunction

  function automatic logic [SEC_W-1:0] limit_s(input logic [2:0] sel);
    case (sel)
      3'h0: limit_s = FRT_5M_S;
      3'h1: limit_s = FRT_10M_S;
      3'h2: limit_s = FRT_30M_S;
      3'h3: limit_s = FRT_1H_S;
      3'h4: limit_s = FRT_2H_S;
      3'h5: limit_s = FRT_3H_S;
      default: limit_s = '1;
    endcase
  endfunction

  logic [2*NIN:0] pin_q;
  logic [2*NIN:0] pin_rise;
  frr_sync #(.W(2*NIN+1)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({keypad_stop_key, extension_input, local_input}),
    .q(pin_q),
    .rise(pin_rise)
  );

  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [SRC_W-1:0] rsrc_reg, rsrc_next;
  logic [IDX_W-1:0] psrc_reg, psrc_next;
  logic [NERR-1:0] latch_reg, latch_next;
  logic [IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
  logic rprev_reg, rprev_next, pprev_reg, pprev_next;
  frr_seq_e st_reg, st_next;
  logic [31:0] tick_reg, tick_next;
  logic [SEC_W-1:0] sec_reg, sec_next, tot_reg, tot_next;
  logic [1:0] att_reg, att_next;
  logic [31:0] init_reg, init_next;
  logic fault_reg, fault_next, busy_reg, busy_next, irq_reg, irq_next;
  logic wr, expert, locked, tick, rst_lvl, prst_lvl, rs_rise, key_rise, restart_req;
  logic [NERR-1:0] clr_mask;
  logic [IRQ_W-1:0] ev;

  always_comb begin
    wait_next = ~((avs_read | avs_write) & wait_reg);
    rdata_next = rdata_reg;
    if (avs_read && wait_reg) begin
      case (avs_address)
        OFS_CTRL: rdata_next = 32'(ctrl_reg & ~(expert ? 8'h00 : 8'h10));
        OFS_RST_SRC: rdata_next = 32'(rsrc_reg);
        OFS_PRST_SRC: rdata_next = expert ? 32'(psrc_reg) : 32'h0;
        OFS_LATCH: rdata_next = 32'(latch_reg);
        OFS_STATUS: rdata_next = 32'({busy_reg, fault_reg, st_reg == SEQ_ABORT,
                                      st_reg == SEQ_AR_WAIT, locked});
        OFS_IRQ_STAT: rdata_next = 32'(istat_reg);
        OFS_IRQ_MASK: rdata_next = 32'(imask_reg);
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wr = avs_write & ~wait_reg;
  assign expert = ctrl_reg[CTRL_EXPERT];
  assign locked = |latch_reg;
  assign tick = tick_reg == 32'(TICK_CYCLES - 1);
  assign key_rise = pin_rise[2*NIN];
  assign clr_mask = CLEARABLE & ~err_cause;

  always_comb begin
    case (rsrc_reg[SRC_W-1:IDX_W])
      KIND_INPUT: rst_lvl = pick_input(rsrc_reg[IDX_W-1:0], pin_q[NIN-1:0],
                                       pin_q[2*NIN-1:NIN], ctrl_reg[CTRL_EXTFIT]);
      KIND_BASE: rst_lvl = ctrl_reg[CTRL_IOPROF] & base_cmd_word[rsrc_reg[3:0]];
      KIND_SERIAL: rst_lvl = ctrl_reg[CTRL_IOPROF] & serial_cmd_word[rsrc_reg[3:0]];
      default: rst_lvl = ctrl_reg[CTRL_IOPROF] & fieldbus_cmd_word[rsrc_reg[3:0]];
    endcase
    prst_lvl = expert & pick_input(psrc_reg, pin_q[NIN-1:0], pin_q[2*NIN-1:NIN],
                                   ctrl_reg[CTRL_EXTFIT]);
  end

  assign rs_rise = rst_lvl & ~rprev_reg;
  assign restart_req = expert & (ctrl_reg[CTRL_RESTART] | (prst_lvl & ~pprev_reg));

  always_comb begin
    ctrl_next = ctrl_reg;
    rsrc_next = rsrc_reg;
    psrc_next = psrc_reg;
    imask_next = imask_reg;
    rprev_next = rst_lvl;
    pprev_next = prst_lvl;
    tick_next = tick ? 32'h0 : tick_reg + 32'h1;
    st_next = st_reg;
    sec_next = sec_reg;
    tot_next = tot_reg;
    att_next = att_reg;
    init_next = init_reg;
    latch_next = latch_reg | err_cause;
    ev = '0;
    if (wr) begin
      case (avs_address)
        OFS_CTRL: begin
          ctrl_next = avs_writedata[CTRL_W-1:0];
          if (!avs_writedata[CTRL_EXPERT]) begin
            ctrl_next[CTRL_RESTART] = 1'b0;
          end
        end
        OFS_RST_SRC: rsrc_next = avs_writedata[SRC_W-1:0];
        OFS_PRST_SRC: if (expert) psrc_next = avs_writedata[IDX_W-1:0];
        OFS_IRQ_MASK: imask_next = avs_writedata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (st_reg != SEQ_RS_INIT && (rs_rise || key_rise)) begin
      latch_next = (latch_reg & ~clr_mask) | err_cause;
      ev[IRQ_MANUAL] = 1'b1;
    end
    case (st_reg)
      SEQ_IDLE, SEQ_AR_WAIT, SEQ_ABORT: begin
        if (restart_req && locked) begin
          latch_next = (latch_reg & ~clr_mask) | err_cause;
          ctrl_next[CTRL_RESTART] = 1'b1;
          init_next = 32'h0;
          st_next = SEQ_RS_INIT;
        end else if (restart_req) begin
          ctrl_next[CTRL_RESTART] = 1'b0;
        end else if (st_reg == SEQ_IDLE) begin
          if (ctrl_reg[CTRL_AUTO] && locked) begin
            st_next = SEQ_AR_WAIT;
            sec_next = '0;
            tot_next = '0;
            att_next = 2'h0;
          end
        end else if (st_reg == SEQ_AR_WAIT) begin
          if (!locked) begin
            ev[IRQ_AUTO_OK] = 1'b1;
            st_next = SEQ_IDLE;
          end else if (!ctrl_reg[CTRL_AUTO]) begin
            st_next = SEQ_IDLE;
          end else if (tick) begin
            tot_next = tot_reg + 16'h1;
            sec_next = sec_reg + 16'h1;
            if (ctrl_reg[CTRL_W-1:CTRL_FRT_LO] < FRT_UNLIMITED
                && tot_reg + 16'h1 >= limit_s(ctrl_reg[CTRL_W-1:CTRL_FRT_LO])) begin
              ev[IRQ_ABORT] = 1'b1;
              st_next = SEQ_ABORT;
            end else if (sec_reg + 16'h1 >= wait_s(att_reg)) begin
              latch_next = (latch_reg & ~clr_mask) | err_cause;
              sec_next = '0;
              att_next = (att_reg == 2'h3) ? att_reg : att_reg + 2'h1;
            end
          end
        end
      end
      SEQ_RS_INIT: begin
        init_next = init_reg + 32'h1;
        if (init_reg == 32'(INIT_CYCLES - 1)) begin
          latch_next = err_cause;
          ctrl_next[CTRL_RESTART] = 1'b0;
          ev[IRQ_RESTART] = 1'b1;
          st_next = SEQ_IDLE;
        end
      end
      default: st_next = SEQ_IDLE;
    endcase
    istat_next = (istat_reg & ~((wr && avs_address == OFS_IRQ_STAT) ?
                  avs_writedata[IRQ_W-1:0] : '0)) | ev;
    irq_next = |(istat_next & imask_next);
    busy_next = st_next == SEQ_RS_INIT;
    fault_next = (|latch_next) && !(ctrl_next[CTRL_AUTO] && st_next != SEQ_ABORT);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      rsrc_reg <= RST_SRC_DEFAULT;
      psrc_reg <= PRST_SRC_RESET;
      latch_reg <= '0;
      istat_reg <= '0;
      imask_reg <= '0;
      rprev_reg <= 1'b0;
      pprev_reg <= 1'b0;
      st_reg <= SEQ_IDLE;
      tick_reg <= 32'h0;
      sec_reg <= '0;
      tot_reg <= '0;
      att_reg <= 2'h0;
      init_reg <= 32'h0;
      fault_reg <= 1'b0;
      busy_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      rsrc_reg <= rsrc_next;
      psrc_reg <= psrc_next;
      latch_reg <= latch_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      rprev_reg <= rprev_next;
      pprev_reg <= pprev_next;
      st_reg <= st_next;
      tick_reg <= tick_next;
      sec_reg <= sec_next;
      tot_reg <= tot_next;
      att_reg <= att_next;
      init_reg <= init_next;
      fault_reg <= fault_next;
      busy_reg <= busy_next;
      irq_reg <= irq_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign fault_state_out = fault_reg;
  assign reinit_busy = busy_reg;
  assign irq = irq_reg;

  property p_clear_needs_gone;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> (($past(latch_reg) & ~latch_reg & $past(err_cause)) == '0);
  endproperty
  a_clear_needs_gone: assert property (p_clear_needs_gone) else $error("cleared live cause");

  property p_unclearable_kept;
    @(posedge clk) disable iff (!rst_n)
    st_reg != SEQ_RS_INIT |=> ((($past(latch_reg) & ~CLEARABLE) & ~latch_reg) == '0);
  endproperty
  a_unclearable_kept: assert property (p_unclearable_kept) else $error("unclearable dropped");

  property p_key_clears;
    @(posedge clk) disable iff (!rst_n)
    key_rise && st_reg != SEQ_RS_INIT |=> istat_reg[IRQ_MANUAL];
  endproperty
  a_key_clears: assert property (p_key_clears) else $error("key reset lost");

  property p_one_edge;
    @(posedge clk) disable iff (!rst_n)
    rs_rise |=> !rs_rise;
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("level gave two events");

  property p_expert_only;
    @(posedge clk) disable iff (!rst_n)
    !expert && st_reg != SEQ_RS_INIT |=> st_reg != SEQ_RS_INIT;
  endproperty
  a_expert_only: assert property (p_expert_only) else $error("restart without expert");

  property p_locked_only;
    @(posedge clk) disable iff (!rst_n)
    !locked && st_reg != SEQ_RS_INIT |=> st_reg != SEQ_RS_INIT;
  endproperty
  a_locked_only: assert property (p_locked_only) else $error("restart while unlocked");

  property p_cmd_returns;
    @(posedge clk) disable iff (!rst_n)
    st_reg == SEQ_RS_INIT && init_reg == 32'(INIT_CYCLES - 1)
      |=> !ctrl_reg[CTRL_RESTART] && latch_reg == $past(err_cause) && !busy_reg;
  endproperty
  a_cmd_returns: assert property (p_cmd_returns) else $error("restart did not finish");

  property p_hold_fault;
    @(posedge clk) disable iff (!rst_n)
    st_reg == SEQ_AR_WAIT && ctrl_reg[CTRL_AUTO] |-> !fault_reg;
  endproperty
  a_hold_fault: assert property (p_hold_fault) else $error("fault shown during attempts");

  property p_abort_fault;
    @(posedge clk) disable iff (!rst_n)
    st_reg == SEQ_ABORT && locked |-> fault_reg ##1 (st_reg == SEQ_ABORT || busy_reg);
  endproperty
  a_abort_fault: assert property (p_abort_fault) else $error("abort not held");

  property p_wait_bound;
    @(posedge clk) disable iff (!rst_n)
    st_reg == SEQ_AR_WAIT |-> sec_reg < wait_s(att_reg);
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("attempt wait overrun");

  c_manual: cover property (@(posedge clk) disable iff (!rst_n) ev[IRQ_MANUAL]);
  c_restart: cover property (@(posedge clk) disable iff (!rst_n) ev[IRQ_RESTART]);
  c_auto_ok: cover property (@(posedge clk) disable iff (!rst_n) ev[IRQ_AUTO_OK]);
  c_abort: cover property (@(posedge clk) disable iff (!rst_n) ev[IRQ_ABORT]);
endmodule

// ---- tb/frr_src_model.sv ----
`timescale 1ns/10ps
module frr_src_model
  import frr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Reset sources
  output logic [frr_pkg::NIN-1:0] local_input,
  output logic [frr_pkg::NIN-1:0] extension_input,
  output logic keypad_stop_key,
  output logic [15:0] base_cmd_word,
  output logic [15:0] serial_cmd_word,
  output logic [15:0] fieldbus_cmd_word
);
  initial begin
    local_input = '0;
    extension_input = '0;
    keypad_stop_key = 1'b0;
    base_cmd_word = 16'h0000;
    serial_cmd_word = 16'h0000;
    fieldbus_cmd_word = 16'h0000;
  end

  // Set one source level just after an edge; index 0 of kind input is the stop key
  task automatic drive(input logic [SRC_W-1:0] sel, input logic v);
    int i;
    i = int'(sel[4:0]);
    @(posedge clk);
    case (sel[6:5])
      KIND_BASE: base_cmd_word[sel[3:0]] <= v;
      KIND_SERIAL: serial_cmd_word[sel[3:0]] <= v;
      KIND_FIELDBUS: fieldbus_cmd_word[sel[3:0]] <= v;
      default: begin
        if (i == 0) begin
          keypad_stop_key <= v;
        end else if (i < int'(EXT_FIRST)) begin
          local_input[i-1] <= v;
        end else begin
          extension_input[i-int'(EXT_FIRST)] <= v;
        end
      end
    endcase
  endtask

  // Active-high request held n+1 cycles
  task automatic pulse(input logic [SRC_W-1:0] sel, input int n);
    drive(sel, 1'b1);
    repeat (n) @(posedge clk);
    drive(sel, 1'b0);
  endtask
endmodule

// ---- tb/tb_fault_reset_restart_control.sv ----
`timescale 1ns/10ps
module tb_fault_reset_restart_control;
  import frr_pkg::*;
  localparam logic [7:0] CLR = 8'h0F;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, keypad_stop_key;
  logic fault_state_out, reinit_busy, irq;
  logic [AW-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [NIN-1:0] local_input, extension_input;
  logic [15:0] base_cmd_word, serial_cmd_word, fieldbus_cmd_word;
  logic [7:0] err_cause, c, ctl;
  logic [SRC_W-1:0] s;
  int n_fail, tests_run, k, seed;

  frr_ctrl #(.TICK_CYCLES(10), .INIT_CYCLES(16)) dut_u (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .local_input(local_input),
    .extension_input(extension_input), .keypad_stop_key(keypad_stop_key),
    .base_cmd_word(base_cmd_word), .serial_cmd_word(serial_cmd_word),
    .fieldbus_cmd_word(fieldbus_cmd_word), .err_cause(err_cause),
    .fault_state_out(fault_state_out), .reinit_busy(reinit_busy), .irq(irq));

  frr_src_model src_u (
    .clk(clk), .local_input(local_input), .extension_input(extension_input),
    .keypad_stop_key(keypad_stop_key), .base_cmd_word(base_cmd_word),
    .serial_cmd_word(serial_cmd_word), .fieldbus_cmd_word(fieldbus_cmd_word));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One Avalon access; entered just after a rising edge
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int w;
    w = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && w < 50) begin
      @(posedge clk);
      w++;
    end
    if (w >= 50) n_fail++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    k = 0;
    while (reinit_busy !== lvl && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask

  function automatic logic [31:0] exp_latch(input logic [7:0] l, input logic [7:0] cause);
    return {24'h0, l & ~(CLR & ~cause)};
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_cause = 8'h00;
    seed = $urandom(32'hE33D3AB5);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_RST_SRC, v); chk("rst_src", v, 32'h02);
    rd(OFS_PRST_SRC, v); chk("prst_src", v, 32'h0);
    rd(5'h1C, v); chk("unmapped", v, 32'h0);
    // Manual clear from the default input, random surviving causes
    c = 8'($urandom_range(255));
    err_cause <= 8'hFF;
    repeat (3) @(posedge clk);
    err_cause <= c;
    src_u.pulse({KIND_INPUT, 5'h02}, 4);
    repeat (6) @(posedge clk);
    rd(OFS_LATCH, v); chk("latch_clear", v, exp_latch(8'hFF, c));
    err_cause <= 8'h00;
    // Level held high gives one event only
    src_u.drive({KIND_INPUT, 5'h02}, 1'b1);
    repeat (6) @(posedge clk);
    err_cause <= 8'hFF;
    repeat (2) @(posedge clk);
    err_cause <= 8'h00;
    repeat (8) @(posedge clk);
    rd(OFS_LATCH, v); chk("latch_level", v, 32'hFF);
    src_u.drive({KIND_INPUT, 5'h02}, 1'b0);
    src_u.pulse({KIND_INPUT, 5'h00}, 3);
    repeat (6) @(posedge clk);
    rd(OFS_LATCH, v); chk("latch_key", v, 32'hF0);
    // Selector kinds; the last three must not clear
    for (int i = 0; i < 8; i++) begin
      ctl = (i == 5) ? 8'h08 : (i == 6) ? 8'h04 : 8'h0C;
      case (i)
        0: s = {KIND_INPUT, 5'(1 + $urandom_range(5))};
        1, 5: s = {KIND_INPUT, 5'(11 + $urandom_range(5))};
        2, 6: s = {KIND_BASE, 1'b0, 4'($urandom_range(15))};
        3: s = {KIND_SERIAL, 1'b0, 4'($urandom_range(15))};
        4: s = {KIND_FIELDBUS, 1'b0, 4'($urandom_range(15))};
        default: s = {KIND_INPUT, 5'h07};
      endcase
      wr(OFS_CTRL, {24'h0, ctl});
      wr(OFS_RST_SRC, {25'h0, s});
      err_cause <= 8'h01;
      repeat (2) @(posedge clk);
      err_cause <= 8'h00;
      src_u.pulse(s, 2 + $urandom_range(4));
      repeat (6) @(posedge clk);
      rd(OFS_LATCH, v); chk("latch_sel", v, (i < 5) ? 32'hF0 : 32'hF1);
    end
    // Restart refused without expert level
    wr(OFS_CTRL, 32'h10);
    repeat (4) @(posedge clk);
    chk("busy_noexp", reinit_busy, 1'b0);
    rd(OFS_CTRL, v); chk("ctrl_noexp", v, 32'h00);
    wr(OFS_PRST_SRC, 32'h03);
    rd(OFS_PRST_SRC, v); chk("prst_noexp", v, 32'h00);
    // Expert restart while locked
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_IRQ_STAT, 32'h0F);
    wr(OFS_CTRL, 32'h12);
    wait_busy(1'b1, 40);
    wait_busy(1'b0, 100);
    chk("init_len", k, 16);
    rd(OFS_CTRL, v); chk("ctrl_back", v, 32'h02);
    rd(OFS_LATCH, v); chk("latch_init", v, 32'h00);
    rd(OFS_IRQ_STAT, v); chk("irq_stat", v, 32'h02);
    chk("irq_masked", irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h02);
    repeat (2) @(posedge clk);
    chk("irq_on", irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h02);
    repeat (2) @(posedge clk);
    chk("irq_off", irq, 1'b0);
    rd(OFS_IRQ_STAT, v); chk("irq_w1c", v, 32'h00);
    // Restart ignored when not locked
    wr(OFS_CTRL, 32'h12);
    repeat (4) @(posedge clk);
    chk("busy_unlock", reinit_busy, 1'b0);
    rd(OFS_CTRL, v); chk("ctrl_unlock", v, 32'h02);
    // Restart from an assigned input
    wr(OFS_PRST_SRC, 32'h03);
    rd(OFS_PRST_SRC, v); chk("prst_src_rw", v, 32'h03);
    err_cause <= 8'h80;
    repeat (2) @(posedge clk);
    err_cause <= 8'h00;
    src_u.pulse({KIND_INPUT, 5'h03}, 3);
    wait_busy(1'b1, 20);
    chk("busy_pin", reinit_busy, 1'b1);
    wait_busy(1'b0, 100);
    rd(OFS_LATCH, v); chk("latch_pin", v, 32'h00);
    // Auto reset: attempts at 1 and 6 ticks, cause gone at 3
    wr(OFS_CTRL, 32'h01);
    err_cause <= 8'h01;
    repeat (5) @(posedge clk);
    chk("fault_auto", fault_state_out, 1'b0);
    repeat (25) @(posedge clk);
    err_cause <= 8'h00;
    repeat (18) @(posedge clk);
    rd(OFS_LATCH, v); chk("latch_wait", v, 32'h01);
    rd(OFS_STATUS, v); chk("status_auto", v & 32'h1F, 32'h03);
    repeat (23) @(posedge clk);
    rd(OFS_LATCH, v); chk("latch_auto", v, 32'h00);
    rd(OFS_IRQ_STAT, v); chk("irq_auto", v, 32'h06);
    // Auto abort after 300 ticks
    err_cause <= 8'h02;
    repeat (2500) @(posedge clk);
    chk("fault_run", fault_state_out, 1'b0);
    k = 0;
    while (fault_state_out !== 1'b1 && k < 1500) begin
      @(posedge clk);
      k++;
    end
    chk("fault_abort", fault_state_out, 1'b1);
    err_cause <= 8'h00;
    repeat (200) @(posedge clk);
    rd(OFS_LATCH, v); chk("latch_abort", v, 32'h02);
    rd(OFS_STATUS, v); chk("status_abort", v & 32'h0D, 32'h0D);
    rd(OFS_IRQ_STAT, v); chk("irq_abort", v[3], 1'b1);
    wr(OFS_CTRL, 32'h13);
    wait_busy(1'b1, 40);
    wait_busy(1'b0, 100);
    repeat (2) @(posedge clk);
    chk("fault_cleared", fault_state_out, 1'b0);
    give_verdict();
  end
endmodule
